// ===== hdl/gpc_port.sv
// General purpose port block with bank B change interrupt
`timescale 1ns/10ps
module gpc_port #(
  parameter int NUM_PORTS   = 9,
  parameter bit HAS_J_PU    = 1'b1
) (
  input  wire logic                                  clock,
  input  wire logic                                  rst_n,
  input  wire logic [7:0]                            addr,
  input  wire logic [7:0]                            wdata,
  input  wire logic                                  wr_en,
  input  wire logic                                  rd_en,
  output logic      [7:0]                            rdata,
  input  wire logic [NUM_PORTS*gpc_pkg::PORT_W-1:0]  pin_in,
  output logic      [NUM_PORTS*gpc_pkg::PORT_W-1:0]  pin_out,
  output logic      [NUM_PORTS*gpc_pkg::PORT_W-1:0]  pin_oe_n,
  output logic      [NUM_PORTS*gpc_pkg::PORT_W-1:0]  pullup_en,
  input  wire logic [NUM_PORTS*gpc_pkg::PORT_W-1:0]  periph_sel,
  input  wire logic [NUM_PORTS*gpc_pkg::PORT_W-1:0]  periph_out,
  input  wire logic [NUM_PORTS*gpc_pkg::PORT_W-1:0]  periph_oe_n,
  output logic                                       irq,
  output logic                                       irq_high
);
  localparam int         W    = gpc_pkg::PORT_W;
  localparam logic [3:0] NP   = 4'(NUM_PORTS);
  localparam bit         J_PU = HAS_J_PU && (NUM_PORTS == gpc_pkg::MAX_PORTS);

  // Variant check
  generate
    if (NUM_PORTS < gpc_pkg::MIN_PORTS || NUM_PORTS > gpc_pkg::MAX_PORTS)
    begin : g_bad
      $error("NUM_PORTS must lie between 7 and 9");
    end
    // Field layout checks
    if (gpc_pkg::PORT_W != 8)
    begin : g_bad_w
      $error("Port width must be 8");
    end
    if (gpc_pkg::CHG_HI - gpc_pkg::CHG_LO != 3)
    begin : g_bad_chg
      $error("Change window must span four pins");
    end
    if (gpc_pkg::CHG_HI >= gpc_pkg::PORT_W)
    begin : g_bad_chg_top
      $error("Change window must lie inside the port");
    end
    if (gpc_pkg::BANK_B >= gpc_pkg::MIN_PORTS || gpc_pkg::BANK_D >= gpc_pkg::MIN_PORTS
        || gpc_pkg::BANK_E >= gpc_pkg::MIN_PORTS || gpc_pkg::BANK_G >= gpc_pkg::MIN_PORTS)
    begin : g_bad_bank
      $error("Banks B to G must exist in every variant");
    end
    if (gpc_pkg::BANK_J != gpc_pkg::MAX_PORTS - 1)
    begin : g_bad_j
      $error("Bank J must be the last port");
    end
    if (gpc_pkg::MAX_PORTS > 16)
    begin : g_bad_max
      $error("Port field of the address holds sixteen ports");
    end
    if (gpc_pkg::SUB_DIR == gpc_pkg::SUB_PINS || gpc_pkg::SUB_PINS == gpc_pkg::SUB_HOLD
        || gpc_pkg::SUB_DIR == gpc_pkg::SUB_HOLD)
    begin : g_bad_sub
      $error("Port register codes must differ");
    end
    if (gpc_pkg::ADDR_IRQ_CTRL[7:6] == 2'h0 || gpc_pkg::ADDR_IRQ_CTL2[7:6] == 2'h0)
    begin : g_bad_addr
      $error("Control registers must sit above the port window");
    end
    if (gpc_pkg::CTRL_FLAG_BIT == gpc_pkg::CTRL_EN_BIT)
    begin : g_bad_ctrl
      $error("Flag and enable bits must differ");
    end
    if (gpc_pkg::CTL2_PRIO_BIT == gpc_pkg::CTL2_PU_B_BIT)
    begin : g_bad_ctl2
      $error("Priority and pull-up bits must differ");
    end
    if (gpc_pkg::G_PU_D_BIT == gpc_pkg::G_PU_E_BIT || gpc_pkg::G_PU_E_BIT == gpc_pkg::G_PU_J_BIT)
    begin : g_bad_gpu
      $error("Pull-up enable bits must differ");
    end
  endgenerate

  logic [NUM_PORTS-1:0][W-1:0] dir_q;
  logic [NUM_PORTS-1:0][W-1:0] dir_d;
  logic [NUM_PORTS-1:0][W-1:0] hold_q;
  logic [NUM_PORTS-1:0][W-1:0] hold_d;
  logic [NUM_PORTS-1:0][W-1:0] pins;
  logic                        flag_q;
  logic                        flag_d;
  logic                        chg_en_q;
  logic                        chg_en_d;
  logic                        prio_q;
  logic                        prio_d;
  logic                        pu_b_q;
  logic                        pu_b_d;
  logic                        pu_d_q;
  logic                        pu_d_d;
  logic                        pu_e_q;
  logic                        pu_e_d;
  logic                        pu_j_q;
  logic                        pu_j_d;
  logic [3:0]                  last_q;
  logic [3:0]                  last_d;
  logic                        primed_q;
  logic                        primed_d;
  logic [7:0]                  rdata_q;
  logic [7:0]                  rdata_d;
  logic [3:0]                  sel_port;
  logic [1:0]                  sel_sub;
  logic                        port_hit;
  logic                        chg_event;
  logic [3:0]                  b_now;
  logic [3:0]                  b_dir;
  logic [3:0]                  chg_bits;
  logic                        wr_ctrl;
  logic                        wr_ctl2;
  logic                        wr_gpins;
  logic                        rd_ctrl;
  logic                        rd_ctl2;
  logic                        rd_gpins;
  logic                        port_in_range;
  logic                        sub_mapped;

  assign pins          = pin_in;
  assign sel_port      = addr[5:2];
  assign sel_sub       = addr[1:0];
  assign port_in_range = (addr[7:6] == 2'h0) && (sel_port < NP);
  assign sub_mapped    = (sel_sub != 2'h3);
  assign port_hit      = port_in_range && sub_mapped;

  // Strobe decode for the control registers and the bank G pins register
  assign wr_ctrl  = wr_en && (addr == gpc_pkg::ADDR_IRQ_CTRL);
  assign wr_ctl2  = wr_en && (addr == gpc_pkg::ADDR_IRQ_CTL2);
  assign wr_gpins = wr_en && port_hit && (sel_port == 4'(gpc_pkg::BANK_G))
                    && (sel_sub == gpc_pkg::SUB_PINS);
  assign rd_ctrl  = rd_en && (addr == gpc_pkg::ADDR_IRQ_CTRL);
  assign rd_ctl2  = rd_en && (addr == gpc_pkg::ADDR_IRQ_CTL2);
  assign rd_gpins = rd_en && port_hit && (sel_port == 4'(gpc_pkg::BANK_G))
                    && (sel_sub == gpc_pkg::SUB_PINS);

  // Change detector on bank B upper nibble, one compare per pin
  assign b_now = pins[gpc_pkg::BANK_B][gpc_pkg::CHG_HI:gpc_pkg::CHG_LO];
  assign b_dir = dir_q[gpc_pkg::BANK_B][gpc_pkg::CHG_HI:gpc_pkg::CHG_LO];
  for (genvar gc = 0; gc <= gpc_pkg::CHG_HI - gpc_pkg::CHG_LO; gc++)
  begin : g_chg
    assign chg_bits[gc] = b_dir[gc] & (b_now[gc] ^ last_q[gc]);
  end
  assign chg_event = primed_q & (|chg_bits);

  // Port register writes
  always_comb
  begin
    dir_d  = dir_q;
    hold_d = hold_q;
    if (wr_en && port_hit)
    begin
      unique case (sel_sub)
        gpc_pkg::SUB_DIR:  dir_d[sel_port]  = wdata;
        gpc_pkg::SUB_PINS: hold_d[sel_port] = wdata;
        gpc_pkg::SUB_HOLD: hold_d[sel_port] = wdata;
        default:           hold_d[sel_port] = hold_q[sel_port];
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_q  <= {NUM_PORTS{gpc_pkg::DIR_RST}};
      hold_q <= {NUM_PORTS{gpc_pkg::HOLD_RST}};
    end
    else
    begin
      dir_q  <= dir_d;
      hold_q <= hold_d;
    end
  end

  // Interrupt control and change detector state
  always_comb
  begin
    chg_en_d = chg_en_q;
    prio_d   = prio_q;
    flag_d   = flag_q;
    last_d   = b_now;
    primed_d = 1'b1;
    if (wr_ctrl)
    begin
      chg_en_d = wdata[gpc_pkg::CTRL_EN_BIT];
      if (wdata[gpc_pkg::CTRL_FLAG_BIT])
        flag_d = 1'b0;
    end
    if (wr_ctl2)
      prio_d = wdata[gpc_pkg::CTL2_PRIO_BIT];
    // Set beats a same-cycle clear
    if (chg_event)
      flag_d = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chg_en_q <= 1'b0;
      prio_q   <= 1'b0;
      flag_q   <= 1'b0;
      last_q   <= 4'h0;
      primed_q <= 1'b0;
    end
    else
    begin
      chg_en_q <= chg_en_d;
      prio_q   <= prio_d;
      flag_q   <= flag_d;
      last_q   <= last_d;
      primed_q <= primed_d;
    end
  end

  // Pull-up control
  always_comb
  begin
    pu_b_d = pu_b_q;
    pu_d_d = pu_d_q;
    pu_e_d = pu_e_q;
    pu_j_d = pu_j_q;
    if (wr_ctl2)
      pu_b_d = wdata[gpc_pkg::CTL2_PU_B_BIT];
    if (wr_gpins)
    begin
      pu_d_d = wdata[gpc_pkg::G_PU_D_BIT];
      pu_e_d = wdata[gpc_pkg::G_PU_E_BIT];
      pu_j_d = J_PU ? wdata[gpc_pkg::G_PU_J_BIT] : 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pu_b_q <= 1'b0;
      pu_d_q <= 1'b0;
      pu_e_q <= 1'b0;
      pu_j_q <= 1'b0;
    end
    else
    begin
      pu_b_q <= pu_b_d;
      pu_d_q <= pu_d_d;
      pu_e_q <= pu_e_d;
      pu_j_q <= pu_j_d;
    end
  end

  assign irq      = flag_q & chg_en_q;
  assign irq_high = flag_q & chg_en_q & prio_q;

  // Read path, data valid the cycle after the strobe
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_en)
    begin
      if (port_hit)
      begin
        unique case (sel_sub)
          gpc_pkg::SUB_DIR:  rdata_d = dir_q[sel_port];
          gpc_pkg::SUB_PINS: rdata_d = pins[sel_port];
          gpc_pkg::SUB_HOLD: rdata_d = hold_q[sel_port];
          default:           rdata_d = 8'h00;
        endcase
        if (rd_gpins)
        begin
          rdata_d[gpc_pkg::G_PU_D_BIT] = pu_d_q;
          rdata_d[gpc_pkg::G_PU_E_BIT] = pu_e_q;
          rdata_d[gpc_pkg::G_PU_J_BIT] = pu_j_q;
        end
      end
      else if (rd_ctrl)
      begin
        rdata_d[gpc_pkg::CTRL_EN_BIT]   = chg_en_q;
        rdata_d[gpc_pkg::CTRL_FLAG_BIT] = flag_q;
      end
      else if (rd_ctl2)
      begin
        rdata_d[gpc_pkg::CTL2_PU_B_BIT] = pu_b_q;
        rdata_d[gpc_pkg::CTL2_PRIO_BIT] = prio_q;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // Pin drivers, one instance per port
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      logic pu_ctrl;
      if (gp == gpc_pkg::BANK_B)
      begin : g_pb
        assign pu_ctrl = pu_b_q;
      end
      else if (gp == gpc_pkg::BANK_D)
      begin : g_pd
        assign pu_ctrl = pu_d_q;
      end
      else if (gp == gpc_pkg::BANK_E)
      begin : g_pe
        assign pu_ctrl = pu_e_q;
      end
      else if (gp == gpc_pkg::BANK_J && J_PU)
      begin : g_pj
        assign pu_ctrl = pu_j_q;
      end
      else
      begin : g_pn
        assign pu_ctrl = 1'b0;
      end
      for (genvar gb = 0; gb < W; gb++)
      begin : g_bit
        localparam int I = gp * W + gb;
        logic own_out;
        logic own_oe_n;
        assign own_out      = hold_q[gp][gb];
        assign own_oe_n     = dir_q[gp][gb];
        // Peripheral owns the pin when selected
        assign pin_out[I]   = periph_sel[I] ? periph_out[I] : own_out;
        assign pin_oe_n[I]  = periph_sel[I] ? periph_oe_n[I] : own_oe_n;
        // Pull-up released while the pin drives
        assign pullup_en[I] = pin_oe_n[I] ? pu_ctrl : 1'b0;
      end
    end
  endgenerate
endmodule

// ===== common/gpc_pkg.sv
// Constants shared by the port block
package gpc_pkg;
  localparam int          PORT_W        = 8;
  localparam int          MAX_PORTS     = 9;
  localparam int          MIN_PORTS     = 7;
  // Port indices
  localparam int          BANK_B        = 1;
  localparam int          BANK_D        = 3;
  localparam int          BANK_E        = 4;
  localparam int          BANK_G        = 6;
  localparam int          BANK_J        = 8;
  // Per-port register offsets and control register addresses, port base is index times four
  localparam logic [1:0]  SUB_DIR       = 2'h0;
  localparam logic [1:0]  SUB_PINS      = 2'h1;
  localparam logic [1:0]  SUB_HOLD      = 2'h2;
  localparam logic [7:0]  ADDR_IRQ_CTRL = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_CTL2 = 8'h41;
  // Field positions
  localparam int          CTRL_FLAG_BIT = 0;
  localparam int          CTRL_EN_BIT   = 3;
  localparam int          CTL2_PRIO_BIT = 0;
  localparam int          CTL2_PU_B_BIT = 7;
  localparam int          G_PU_D_BIT    = 7;
  localparam int          G_PU_E_BIT    = 6;
  localparam int          G_PU_J_BIT    = 5;
  localparam int          CHG_LO        = 4;
  localparam int          CHG_HI        = 7;
  // Reset values
  localparam logic [7:0]  DIR_RST       = 8'hff;
  localparam logic [7:0]  HOLD_RST      = 8'h00;
endpackage

// ===== verif/gpc_props.sv
// Assertions on the port block's pins, register reads and interrupt outputs
`timescale 1ns/10ps
module gpc_props #(
  parameter int NUM_PORTS = 9
) (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic [7:0]             addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire logic [7:0]             rdata,
  input wire logic [NUM_PORTS*8-1:0] pin_in,
  input wire logic [NUM_PORTS*8-1:0] pin_out,
  input wire logic [NUM_PORTS*8-1:0] pin_oe_n,
  input wire logic [NUM_PORTS*8-1:0] pullup_en,
  input wire logic [NUM_PORTS*8-1:0] periph_sel,
  input wire logic [NUM_PORTS*8-1:0] periph_oe_n,
  input wire logic                   irq,
  input wire logic                   irq_high
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_pin_read: assert property (rd_en && addr == 8'h05 |=> rdata == $past(pin_in[15:8]))
    else $error("pin read wrong");
  a_pin_write: assert property (wr_en && addr == 8'h05 && periph_sel[15:8] == 8'h00
    |=> pin_out[15:8] == $past(wdata)) else $error("pin write lost");
  a_dir_input: assert property (wr_en && addr == 8'h04 && periph_sel[15:8] == 8'h00
    |=> pin_oe_n[15:8] == $past(wdata)) else $error("direction wrong");
  a_hold_drive: assert property (wr_en && addr == 8'h06 && periph_sel[15:8] == 8'h00
    |=> pin_out[15:8] == $past(wdata)) else $error("hold not driven");
  a_hold_read: assert property (wr_en && addr == 8'h06 ##2 rd_en && addr == 8'h06
    |=> rdata == $past(wdata, 3)) else $error("hold read wrong");
  a_unmapped_zero: assert property (rd_en && addr[1:0] == 2'h3 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_prio_low: assert property (wr_en && addr == 8'h41 && !wdata[0] |=> !irq_high)
    else $error("priority ignored");
  a_en_mask: assert property (wr_en && addr == 8'h40 && !wdata[3] |=> !irq)
    else $error("irq not masked");
  a_pu_out_off: assert property ((pullup_en & ~pin_oe_n) == '0)
    else $error("pull-up on driven pin");
  a_pu_bank_a: assert property (pullup_en[7:0] == 8'h00)
    else $error("pull-up on bank A");
  a_periph_owns: assert property (periph_sel[23:16] == 8'hff
    |-> pin_oe_n[23:16] == periph_oe_n[23:16]) else $error("peripheral not in control");
endmodule
bind gpc_port gpc_props #(.NUM_PORTS(NUM_PORTS)) u_props (.clock(clock), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
  .periph_sel(periph_sel), .periph_oe_n(periph_oe_n), .irq(irq), .irq_high(irq_high));

// ===== verif/gpc_pins.sv
// Model of the outside signals on the port pins
`timescale 1ns/10ps
module gpc_pins (
  input  wire logic [71:0] pin_out,
  input  wire logic [71:0] pin_oe_n,
  input  wire logic [71:0] pullup_en,
  input  wire logic [71:0] ext_val,
  input  wire logic [71:0] ext_en,
  output logic      [71:0] pin_in
);
  // Driver first, then outside source, then pull-up, else the inverse of pin_out
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & (pullup_en | ~pin_out));
endmodule

// ===== verif/tb.sv
// Testbench for the port block
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  logic        clock, rst_n, wr_en, rd_en, irq, irq_high;
  logic [7:0]  addr, wdata, rdata, d;
  logic [71:0] pin_in, pin_out, pin_oe_n, pullup_en, sel, p_out, p_oe_n, ext_val, ext_en;
  int          fails, comparisons;
  gpc_port u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .periph_sel(sel), .periph_out(p_out), .periph_oe_n(p_oe_n),
    .irq(irq), .irq_high(irq_high));
  gpc_pins u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task close_out;
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task t_port;
    wr(8'h04, 8'hf0);
    wr(8'h06, 8'h5a);
    `CHK("oe_n", 8'hf0, pin_oe_n[15:8])
    `CHK("out", 8'h5a, pin_out[15:8])
    rd(8'h05);
    `CHK("pins", 8'h9a, d)
    rd(8'h06);
    `CHK("hold", 8'h5a, d)
    wr(8'h05, 8'h33);
    rd(8'h06);
    `CHK("hold", 8'h33, d)
    rd(8'h07);
    `CHK("unmapped", 8'h00, d)
    rd(8'h20);
    `CHK("dir j", 8'hff, d)
    rd(8'h24);
    `CHK("no port", 8'h00, d)
  endtask
  task t_pu;
    wr(8'h41, 8'h80);
    `CHK("pu b", 8'hf0, pullup_en[15:8])
    wr(8'h19, 8'he0);
    `CHK("pu dej", 24'hffffff, {pullup_en[71:64], pullup_en[39:24]})
    `CHK("pu a", 8'h00, pullup_en[7:0])
  endtask
  task t_chg;
    wr(8'h40, 8'h01);
    wr(8'h40, 8'h08);
    `CHK("irq", 1'b0, irq)
    @(posedge clock);
    ext_val[12] <= 1'b0;
    repeat (2) @(posedge clock);
    #1 `CHK("irq", 1'b1, irq)
    rd(8'h40);
    `CHK("flag", 8'h09, d & 8'h09)
    `CHK("hi", 1'b0, irq_high)
    wr(8'h41, 8'h81);
    `CHK("hi", 1'b1, irq_high)
    wr(8'h40, 8'h09);
    `CHK("clr", 1'b0, irq)
    wr(8'h04, 8'h00);
    wr(8'h06, 8'hf3);
    `CHK("out pin", 1'b0, irq)
    wr(8'h04, 8'hf0);
    wr(8'h40, 8'h00);
    `CHK("mask", 1'b0, irq)
    rd(8'h40);
    `CHK("flag", 1'b1, d[0])
  endtask
  task t_per;
    @(posedge clock);
    sel[23:16]    <= 8'hff;
    p_out[23:16]  <= 8'h3c;
    p_oe_n[23:16] <= 8'h00;
    @(posedge clock);
    #1 `CHK("per out", 8'h3c, pin_out[23:16])
    `CHK("per oe", 8'h00, pin_oe_n[23:16])
  endtask
  initial
  begin
    rst_n   = 1'b0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = 8'h00;
    wdata   = 8'h00;
    sel     = '0;
    p_out   = '0;
    p_oe_n  = '1;
    ext_val = 72'h9000;
    ext_en  = 72'hf000;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1 `CHK("oe_n", {72{1'b1}}, pin_oe_n)
    `CHK("pu", 72'h0, pullup_en)
    t_port;
    t_pu;
    t_chg;
    t_per;
    close_out;
  end
  initial
  begin
    #20000;
    fails++;
    close_out;
  end
endmodule
